// file: tic_map.vh
`ifndef TIC_MAP_VH
`define TIC_MAP_VH

// Clock and time base
`define TIC_CLK_HZ 28'd200000000
`define TIC_CLK_PERIOD_NS 5
`define TIC_TICK_NS 10000000
`define TIC_TICKS_PER_GATE 4'd10

// Terminal command methods
`define TIC_MODE_2W1 2'h0
`define TIC_MODE_2W2 2'h1
`define TIC_MODE_3W1 2'h2
`define TIC_MODE_3W2 2'h3

// Digital terminal positions
`define TIC_DI_FWD 0
`define TIC_DI_REV 1
`define TIC_DI_EN 2
`define TIC_DI_UP 3
`define TIC_DI_DOWN 4

// Decimal point and rate
`define TIC_DEC_HUNDREDTHS 2'h1
`define TIC_DEC_THOUSANDTHS 2'h2
`define TIC_RATE_X10 4'hA

// Limits and documented defaults
`define TIC_FREQ_MAX 32'h0009C400
`define TIC_PULSE_XMAX 16'h2710
`define TIC_PULSE_XMAX_DEF 16'h1388
`define TIC_AI_XMAX_DEF 16'h03E8
`define TIC_AI3_XMIN_DEF 16'hFC18
`define TIC_AI3_YMIN_DEF 16'hD8F0
`define TIC_Y_FULL_DEF 16'h2710
`define TIC_CURVE_SEL_DEF 12'h321
`define TIC_FILTER_DEF 10'h00A
`define TIC_FILTER_SHIFT 3

`endif

// file: tic_curve.v
`timescale 1ns/1ps
`include "tic_map.vh"

module tic_curve (
  // Input sample and curve points
  input wire signed [15:0] x,
  input wire signed [15:0] x_min,
  input wire signed [15:0] x_max,
  input wire signed [15:0] y_min,
  input wire signed [15:0] y_max,
  // Below-minimum option
  input wire below_zero,
  // Result
  output reg signed [15:0] y
);
  wire signed [16:0] dx = {x[15], x} - {x_min[15], x_min};
  wire signed [16:0] span = {x_max[15], x_max} - {x_min[15], x_min};
  wire signed [16:0] dy = {y_max[15], y_max} - {y_min[15], y_min};
  wire signed [33:0] prod = dx * dy;
  // Zero span is caught below, so the quotient never divides by zero
  wire signed [33:0] quot = (span == 17'sd0) ? 34'sd0 : prod / span;
  wire signed [16:0] interp = {y_min[15], y_min} + quot[16:0];

  always @* begin
    if (x >= x_max) begin
      y = y_max; // see RULE_09
    end else if (x < x_min) begin
      y = below_zero ? 16'h0000 : y_min; // see RULE_11
    end else begin
      y = interp[15:0]; // see RULE_10
    end
  end
endmodule

// file: tic_terminal_input.v
// Contract
// RULE_01: Method zero: equal switches stop, else direction.
// RULE_02: Method one: forward enables, reverse picks direction.
// RULE_03: Three-wire one: pulses start, enable open stops.
// RULE_04: Installer assigns enable terminal function three.
// RULE_05: Three-wire two: forward pulse runs, reverse sets direction.
// RULE_06: Three-wire two: enable inactive always stops.
// RULE_07: UP/DOWN ramp set frequency at programmed rate.
// RULE_08: Rate step follows frequency decimal setting.
// RULE_09: Input above maximum point treated as maximum.
// RULE_10: Linear interpolation between the two points.
// RULE_11: Below minimum: minimum setting or zero.
// RULE_12: Below-minimum option per input, ones and tens.
// RULE_13: Current mode: 1mA counts as 0.5V.
// RULE_14: Programmable first-order filter per analog input.
// RULE_15: Third curve accepts bipolar points.
// RULE_16: Pulse curve on fifth input, max 100kHz.
// RULE_17: Curve select digits choose curve per input.
// RULE_18: First three inputs get programmable delay.
// RULE_19: Polarity option selects valid level per input.
`timescale 1ns/1ps
`include "tic_map.vh"

module tic_terminal_input #(
  parameter TICK_CYC = `TIC_TICK_NS / `TIC_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Digital terminals, high when connected to common
  input wire [4:0] term_raw,
  input wire pulse_capable_input,
  input wire [4:0] input_polarity_select,
  // Delays for first three terminals, 0.1 s units
  input wire [15:0] x1_delay,
  input wire [15:0] x2_delay,
  input wire [15:0] x3_delay,
  // Run command setup
  input wire [1:0] terminal_command_method,
  // Up/down ramp
  input wire [15:0] updown_rate_setting,
  input wire [1:0] frequency_decimal_select,
  // Analog inputs, 0.01 V or 0.01 mA units
  input wire signed [15:0] analog_input_one,
  input wire signed [15:0] analog_input_two,
  input wire ai1_current_mode,
  input wire ai2_current_mode,
  // Filter times, 0.01 s units
  input wire [9:0] ai1_filter_time,
  input wire [9:0] ai2_filter_time,
  input wire [9:0] pulse_filter_time,
  // Curve points, 0.01 V / 0.01 %
  input wire signed [15:0] c1_x_min,
  input wire signed [15:0] c1_y_min,
  input wire signed [15:0] c1_x_max,
  input wire signed [15:0] c1_y_max,
  input wire signed [15:0] c2_x_min,
  input wire signed [15:0] c2_y_min,
  input wire signed [15:0] c2_x_max,
  input wire signed [15:0] c2_y_max,
  input wire signed [15:0] c3_x_min,
  input wire signed [15:0] c3_y_min,
  input wire signed [15:0] c3_x_max,
  input wire signed [15:0] c3_y_max,
  // Pulse curve, 0.01 kHz / 0.01 %
  input wire signed [15:0] p_x_min,
  input wire signed [15:0] p_y_min,
  input wire signed [15:0] p_x_max,
  input wire signed [15:0] p_y_max,
  // Selections, BCD digits
  input wire [11:0] curve_select_setting,
  input wire [7:0] below_min_select,
  // Results
  output reg run_cmd_r,
  output reg reverse_cmd_r,
  output reg [31:0] set_freq_r,
  output reg signed [15:0] ai1_setting_r,
  output reg signed [15:0] ai2_setting_r,
  output reg signed [15:0] pulse_setting_r,
  output reg [15:0] pulse_freq_r
);
  localparam ST_STOP = 2'h0;
  localparam ST_FWD = 2'h1;
  localparam ST_REV = 2'h2;

  // Curve point picked by a BCD digit; out-of-range digits fall to curve 1
  function signed [15:0] pick;
    input [3:0] digit;
    input signed [15:0] a;
    input signed [15:0] b;
    input signed [15:0] c;
    begin
      case (digit)
        4'h2: pick = b;
        4'h3: pick = c;
        default: pick = a;
      endcase
    end
  endfunction

  // Time base: 10 ms tick and 100 ms gate
  reg [31:0] tick_cnt_r;
  reg [3:0] gate_cnt_r;
  wire tick = (tick_cnt_r == TICK_CYC - 1);
  wire gate = tick && (gate_cnt_r == `TIC_TICKS_PER_GATE - 4'h1);

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_r <= 32'h00000000;
      gate_cnt_r <= 4'h0;
    end else begin
      tick_cnt_r <= tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
      if (gate) begin
        gate_cnt_r <= 4'h0;
      end else if (tick) begin
        gate_cnt_r <= gate_cnt_r + 4'h1;
      end
    end
  end

  // Valid levels after polarity
  wire [4:0] term_valid = term_raw ^ input_polarity_select; // see RULE_19

  // Delayed state of the first three terminals
  wire [47:0] dly_all = {x3_delay, x2_delay, x1_delay};
  wire [2:0] dly_state;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_dly
      reg st_r;
      reg [15:0] cnt_r;
      assign dly_state[g] = st_r;
      // A bounce back cancels the pending change and restarts the wait
      always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          st_r <= 1'b0;
          cnt_r <= 16'h0000;
        end else if (term_valid[g] == st_r) begin
          cnt_r <= 16'h0000;
        end else if (dly_all[g*16 +: 16] == 16'h0000 || cnt_r > dly_all[g*16 +: 16]) begin
          st_r <= term_valid[g]; // see RULE_18
          cnt_r <= 16'h0000;
        end else if (gate) begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  endgenerate

  wire forward_input = dly_state[`TIC_DI_FWD];
  wire reverse_input = dly_state[`TIC_DI_REV];
  wire en = dly_state[`TIC_DI_EN];
  wire up = term_valid[`TIC_DI_UP];
  wire down = term_valid[`TIC_DI_DOWN];

  // Run command state machine
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg fwd_prev_r;
  reg rev_prev_r;
  wire fwd_rise = forward_input && !fwd_prev_r;
  wire rev_rise = reverse_input && !rev_prev_r;

  always @* begin
    state_nxt = state_r;
    case (terminal_command_method)
      `TIC_MODE_2W1: begin
        if (forward_input && !reverse_input) begin
          state_nxt = ST_FWD; // see RULE_01
        end else if (reverse_input && !forward_input) begin
          state_nxt = ST_REV; // see RULE_01
        end else begin
          state_nxt = ST_STOP; // see RULE_01
        end
      end
      `TIC_MODE_2W2: begin
        state_nxt = !forward_input ? ST_STOP : (reverse_input ? ST_REV : ST_FWD); // see RULE_02
      end
      `TIC_MODE_3W1: begin
        // Enable comes from terminal function three; see RULE_04
        if (!en) begin
          state_nxt = ST_STOP; // see RULE_03
        end else if (fwd_rise) begin
          state_nxt = ST_FWD; // see RULE_03
        end else if (rev_rise) begin
          state_nxt = ST_REV; // see RULE_03
        end
      end
      `TIC_MODE_3W2: begin
        if (!en) begin
          state_nxt = ST_STOP; // see RULE_06
        end else if (fwd_rise || state_r != ST_STOP) begin
          state_nxt = reverse_input ? ST_REV : ST_FWD; // see RULE_05
        end
      end
      default: state_nxt = ST_STOP;
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_STOP;
      fwd_prev_r <= 1'b0;
      rev_prev_r <= 1'b0;
      run_cmd_r <= 1'b0;
      reverse_cmd_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      fwd_prev_r <= forward_input;
      rev_prev_r <= reverse_input;
      run_cmd_r <= (state_nxt != ST_STOP);
      reverse_cmd_r <= (state_nxt == ST_REV);
    end
  end

  // Up/down ramp: phase accumulator in 0.001 Hz per second units
  wire [19:0] rate_eff = (frequency_decimal_select == `TIC_DEC_HUNDREDTHS) ?
    updown_rate_setting * `TIC_RATE_X10 : {4'h0, updown_rate_setting}; // see RULE_08
  reg [27:0] acc_r;
  wire [27:0] acc_sum = acc_r + {8'h00, rate_eff};
  wire step = acc_sum >= `TIC_CLK_HZ;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      acc_r <= 28'h0000000;
      set_freq_r <= 32'h00000000;
    end else if (up ^ down) begin
      acc_r <= step ? acc_sum - `TIC_CLK_HZ : acc_sum; // see RULE_07
      if (step && up && set_freq_r < `TIC_FREQ_MAX) begin
        set_freq_r <= set_freq_r + 32'h00000001; // see RULE_07
      end else if (step && down && set_freq_r != 32'h00000000) begin
        set_freq_r <= set_freq_r - 32'h00000001; // see RULE_07
      end
    end else begin
      acc_r <= 28'h0000000;
    end
  end

  // Pulse frequency over a 100 ms gate gives 0.01 kHz units
  reg pulse_prev_r;
  reg [15:0] pulse_cnt_r;
  wire pulse_edge = pulse_capable_input && !pulse_prev_r;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pulse_prev_r <= 1'b0;
      pulse_cnt_r <= 16'h0000;
      pulse_freq_r <= 16'h0000;
    end else begin
      pulse_prev_r <= pulse_capable_input;
      if (gate) begin
        pulse_freq_r <= pulse_cnt_r; // see RULE_16
        // An edge on the gate cycle opens the next window, so none is lost
        pulse_cnt_r <= pulse_edge ? 16'h0001 : 16'h0000;
      end else if (pulse_edge && pulse_cnt_r != 16'hFFFF) begin
        pulse_cnt_r <= pulse_cnt_r + 16'h0001;
      end
    end
  end

  // Current mode halves the value: 1 mA reads as 0.5 V
  wire signed [15:0] ai1_scaled = ai1_current_mode ? (analog_input_one >>> 1)
    : analog_input_one; // see RULE_13
  wire signed [15:0] ai2_scaled = ai2_current_mode ? (analog_input_two >>> 1)
    : analog_input_two; // see RULE_13

  // First-order filters; step period is the time constant over eight
  wire [47:0] flt_in = {pulse_freq_r, ai2_scaled, ai1_scaled};
  wire [29:0] flt_time = {pulse_filter_time, ai2_filter_time, ai1_filter_time};
  wire [47:0] flt_out;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_flt
      reg signed [15:0] val_r;
      reg [9:0] cnt_r;
      wire signed [15:0] x = flt_in[g*16 +: 16];
      wire [9:0] t = flt_time[g*10 +: 10];
      wire signed [16:0] diff = {x[15], x} - {val_r[15], val_r};
      wire signed [16:0] stepv = diff >>> `TIC_FILTER_SHIFT;
      wire signed [16:0] nextv = {val_r[15], val_r} + stepv;
      assign flt_out[g*16 +: 16] = val_r;
      // Longer time steadies the value at the cost of response
      always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          val_r <= 16'h0000;
          cnt_r <= 10'h000;
        end else if (t == 10'h000) begin
          val_r <= x; // see RULE_14
          cnt_r <= 10'h000;
        end else if (tick) begin
          if (cnt_r >= (t >> `TIC_FILTER_SHIFT)) begin
            val_r <= (stepv == 17'sd0) ? x : nextv[15:0]; // see RULE_14
            cnt_r <= 10'h000;
          end else begin
            cnt_r <= cnt_r + 10'h001;
          end
        end
      end
    end
  endgenerate

  // Curve choice per analog input; curve 3 points may go negative
  wire [3:0] sel1 = curve_select_setting[3:0]; // see RULE_17
  wire [3:0] sel2 = curve_select_setting[7:4]; // see RULE_17
  wire signed [15:0] ai1_y;
  wire signed [15:0] ai2_y;
  wire signed [15:0] pls_y;
  wire signed [15:0] p_x_max_eff = (p_x_max > $signed(`TIC_PULSE_XMAX)) ?
    $signed(`TIC_PULSE_XMAX) : p_x_max; // see RULE_16

  tic_curve u_ai1 (
    .x(flt_out[15:0]),
    .x_min(pick(sel1, c1_x_min, c2_x_min, c3_x_min)), // see RULE_15
    .x_max(pick(sel1, c1_x_max, c2_x_max, c3_x_max)),
    .y_min(pick(sel1, c1_y_min, c2_y_min, c3_y_min)),
    .y_max(pick(sel1, c1_y_max, c2_y_max, c3_y_max)),
    .below_zero(below_min_select[0]), // see RULE_12
    .y(ai1_y)
  );

  tic_curve u_ai2 (
    .x(flt_out[31:16]),
    .x_min(pick(sel2, c1_x_min, c2_x_min, c3_x_min)),
    .x_max(pick(sel2, c1_x_max, c2_x_max, c3_x_max)),
    .y_min(pick(sel2, c1_y_min, c2_y_min, c3_y_min)),
    .y_max(pick(sel2, c1_y_max, c2_y_max, c3_y_max)),
    .below_zero(below_min_select[4]), // see RULE_12
    .y(ai2_y)
  );

  tic_curve u_pls (
    .x(flt_out[47:32]),
    .x_min(p_x_min),
    .x_max(p_x_max_eff),
    .y_min(p_y_min),
    .y_max(p_y_max),
    .below_zero(1'b0),
    .y(pls_y)
  );

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ai1_setting_r <= 16'h0000;
      ai2_setting_r <= 16'h0000;
      pulse_setting_r <= 16'h0000;
    end else begin
      ai1_setting_r <= ai1_y; // see RULE_10
      ai2_setting_r <= ai2_y; // see RULE_10
      pulse_setting_r <= pls_y; // see RULE_16
    end
  end
endmodule

// file: tic_src.sv
`timescale 1ns/1ps
module tic_src (
  // Clock
  input wire clock,
  // Burst enable and half period in cycles
  input wire en,
  input wire [7:0] half,
  // Pulse train toward the fifth input
  output reg pulse
);
  reg [7:0] cnt_r = 8'h00;
  initial pulse = 1'b0;
  // Idle low between bursts so no stray edge is counted
  always @(posedge clock) begin
    if (!en || cnt_r == half - 8'h01) begin
      cnt_r <= 8'h00;
      pulse <= en ? ~pulse : 1'b0;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

// file: tic_chk.sv
`timescale 1ns/1ps
`include "tic_map.vh"
module tic_chk (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Terminals and setup
  input wire [4:0] term_raw,
  input wire [4:0] input_polarity_select,
  input wire [15:0] x1_delay,
  input wire [15:0] x2_delay,
  input wire [15:0] x3_delay,
  input wire [1:0] terminal_command_method,
  // Results
  input wire run_cmd_r,
  input wire reverse_cmd_r,
  input wire [31:0] set_freq_r
);
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Run-command checks only judged with no delay and active-high terminals
  wire plain = ~|{x1_delay, x2_delay, x3_delay, input_polarity_select};
  wire [1:0] sw = term_raw[1:0];
  wire a0 = plain && terminal_command_method == 2'h0;
  wire a1 = plain && terminal_command_method == 2'h1;
  chk_two_wire_stop: assert property ((a0 && sw[0] == sw[1])[*4] |-> !run_cmd_r)
    else $error("two-wire equal switches did not stop");
  chk_two_wire_fwd: assert property ((a0 && sw == 2'h1)[*4] |-> run_cmd_r && !reverse_cmd_r)
    else $error("two-wire forward not running");
  chk_enable_rev: assert property ((a1 && sw == 2'h3)[*4] |-> run_cmd_r && reverse_cmd_r)
    else $error("enable mode reverse not running");
  chk_enable_stop: assert property ((a1 && !sw[0])[*4] |-> !run_cmd_r)
    else $error("enable mode ran without enable");
  chk_three_wire_stop: assert property ((plain && terminal_command_method[1] && !term_raw[2])[*4] |-> !run_cmd_r)
    else $error("three-wire ran with enable open");
  chk_freq_hold: assert property ((input_polarity_select[4:3] == 2'h0 && term_raw[3] == term_raw[4])[*4] |-> $stable(set_freq_r))
    else $error("set frequency moved without a single ramp key");
  chk_freq_rise: assert property ((input_polarity_select[4:3] == 2'h0 && term_raw[4:3] == 2'h1)[*4] |-> set_freq_r >= $past(set_freq_r))
    else $error("set frequency fell while raising");
  chk_freq_step: assert property (set_freq_r != $past(set_freq_r) |-> set_freq_r - $past(set_freq_r) == 32'h1 || $past(set_freq_r) - set_freq_r == 32'h1)
    else $error("set frequency jumped by more than one step");
  chk_freq_ceiling: assert property (set_freq_r <= `TIC_FREQ_MAX)
    else $error("set frequency above ceiling");
endmodule
bind tic_terminal_input tic_chk u_chk (.clock, .resetn, .term_raw, .input_polarity_select,
  .x1_delay, .x2_delay, .x3_delay, .terminal_command_method, .run_cmd_r, .reverse_cmd_r,
  .set_freq_r);

// file: tic_terminal_input_tb.sv
`timescale 1ns/1ps
`include "tic_map.vh"
module tic_terminal_input_tb;
  reg clock = 1'b0;
  reg resetn = 1'b0;
  reg pen = 1'b0;
  reg [4:0] term_raw = 5'h00, input_polarity_select = 5'h00;
  reg [15:0] x1_delay = 16'h0000, x2_delay = 16'h0000, x3_delay = 16'h0000;
  reg [1:0] terminal_command_method = 2'h0, frequency_decimal_select = 2'h1;
  reg [15:0] updown_rate_setting = 16'hFFFF;
  reg signed [15:0] analog_input_one = 16'h0000, analog_input_two = 16'h0000;
  reg ai1_current_mode = 1'b0, ai2_current_mode = 1'b0;
  reg [9:0] ai1_filter_time = 10'h000, ai2_filter_time = 10'h000, pulse_filter_time = 10'h000;
  reg signed [15:0] c1_x_min = 16'h0000, c1_y_min = 16'h0000, c2_x_min = 16'h0000;
  reg signed [15:0] c1_x_max = `TIC_AI_XMAX_DEF, c1_y_max = `TIC_Y_FULL_DEF, c2_y_min = 16'h0000;
  reg signed [15:0] c2_x_max = `TIC_AI_XMAX_DEF, c2_y_max = `TIC_Y_FULL_DEF;
  reg signed [15:0] c3_x_min = `TIC_AI3_XMIN_DEF, c3_y_min = `TIC_AI3_YMIN_DEF;
  reg signed [15:0] c3_x_max = `TIC_AI_XMAX_DEF, c3_y_max = `TIC_Y_FULL_DEF;
  reg signed [15:0] p_x_min = 16'h0000, p_y_min = 16'h0000, p_x_max = `TIC_PULSE_XMAX_DEF;
  reg signed [15:0] p_y_max = `TIC_Y_FULL_DEF;
  reg [11:0] curve_select_setting = `TIC_CURVE_SEL_DEF;
  reg [7:0] below_min_select = 8'h00;
  wire pulse_capable_input, run_cmd_r, reverse_cmd_r;
  wire [31:0] set_freq_r;
  wire signed [15:0] ai1_setting_r, ai2_setting_r, pulse_setting_r;
  wire [15:0] pulse_freq_r;
  integer fails = 0, samples_checked = 0, m, k;
  tic_src src (.clock, .en(pen), .half(8'h0A), .pulse(pulse_capable_input));
  // Short time base keeps delays, gates and filters inside the run
  tic_terminal_input #(.TICK_CYC(20)) uut (.clock, .resetn, .term_raw, .pulse_capable_input,
    .input_polarity_select, .x1_delay, .x2_delay, .x3_delay, .terminal_command_method,
    .updown_rate_setting, .frequency_decimal_select, .analog_input_one, .analog_input_two,
    .ai1_current_mode, .ai2_current_mode, .ai1_filter_time, .ai2_filter_time,
    .pulse_filter_time, .c1_x_min, .c1_y_min, .c1_x_max, .c1_y_max, .c2_x_min, .c2_y_min,
    .c2_x_max, .c2_y_max, .c3_x_min, .c3_y_min, .c3_x_max, .c3_y_max, .p_x_min, .p_y_min,
    .p_x_max, .p_y_max, .curve_select_setting, .below_min_select, .run_cmd_r,
    .reverse_cmd_r, .set_freq_r, .ai1_setting_r, .ai2_setting_r, .pulse_setting_r,
    .pulse_freq_r);
  initial begin
    forever #2.5 clock = ~clock;
  end
  task end_sim;
    begin
      $display("checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  // Step off the edge so registered outputs have landed
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  task term(input [4:0] v, input integer n);
    begin
      @(posedge clock) term_raw <= v;
      cyc(n);
    end
  endtask
  task runs(input r, input d);
    begin
      chk(run_cmd_r, r);
      chk(reverse_cmd_r, d);
    end
  endtask
  task done(input integer n);
    $display("test %0d finished", n);
  endtask
  initial begin
    #200000;
    fails = fails + 1;
    end_sim;
  end
  initial begin
    cyc(8);
    @(posedge clock) resetn <= 1'b1;
    for (m = 0; m < 2; m = m + 1) begin
      @(posedge clock) terminal_command_method <= m[1:0];
      for (k = 0; k < 4; k = k + 1) begin
        term(k[4:0], 6);
        if (m == 0) runs(k == 1 || k == 2, k == 2);
        else runs(k[0], k == 3);
      end
    end
    done(1);
    term(5'h00, 6);
    @(posedge clock) terminal_command_method <= 2'h2;
    term(5'h01, 6);
    runs(0, 0);
    // Enable sits on bit 2, wired as function three
    term(5'h04, 6);
    term(5'h05, 4);
    term(5'h04, 6);
    runs(1, 0);
    term(5'h00, 6);
    runs(0, 0);
    term(5'h04, 6);
    term(5'h06, 4);
    term(5'h04, 6);
    runs(1, 1);
    term(5'h00, 6);
    @(posedge clock) terminal_command_method <= 2'h3;
    term(5'h06, 6);
    runs(0, 0);
    term(5'h07, 4);
    term(5'h06, 6);
    runs(1, 1);
    term(5'h04, 6);
    runs(1, 0);
    term(5'h00, 6);
    runs(0, 0);
    done(2);
    @(posedge clock) begin
      terminal_command_method <= 2'h0;
      input_polarity_select <= 5'h01;
    end
    cyc(6);
    runs(1, 0);
    term(5'h01, 6);
    runs(0, 0);
    // Polarity flip makes forward valid; a delay setting of two holds the change until the third gate
    @(posedge clock) begin
      input_polarity_select <= 5'h00;
      x1_delay <= 16'h0002;
    end
    cyc(390);
    runs(0, 0);
    cyc(240);
    runs(1, 0);
    term(5'h00, 640);
    runs(0, 0);
    @(posedge clock) x1_delay <= 16'h0000;
    done(3);
    term(5'h08, 3100);
    chk(set_freq_r, 32'hA);
    term(5'h18, 20);
    chk(set_freq_r, 32'hA);
    @(posedge clock) frequency_decimal_select <= 2'h2;
    term(5'h08, 3100);
    chk(set_freq_r, 32'hB);
    // Coarse rate again so the ramp down reaches the floor in time
    @(posedge clock) frequency_decimal_select <= 2'h1;
    term(5'h10, 4000);
    chk(set_freq_r, 32'h0);
    term(5'h00, 4);
    done(4);
    @(posedge clock) begin
      analog_input_one <= 16'h01F4;
      analog_input_two <= 16'h04B0;
    end
    cyc(6);
    chk(ai1_setting_r, 32'h1388);
    chk(ai2_setting_r, 32'h2710);
    @(posedge clock) begin
      c1_x_min <= 16'h00C8;
      c1_y_min <= 16'h03E8;
      c2_x_min <= 16'h00C8;
      c2_y_min <= 16'h03E8;
      below_min_select <= 8'h10;
      analog_input_one <= 16'h0064;
      analog_input_two <= 16'h0064;
    end
    cyc(6);
    chk(ai1_setting_r, 32'h3E8);
    chk(ai2_setting_r, 32'h0);
    @(posedge clock) begin
      ai1_current_mode <= 1'b1;
      ai2_current_mode <= 1'b1;
      analog_input_one <= 16'h04B0;
      curve_select_setting <= 12'h331;
      analog_input_two <= 16'hFC18;
    end
    cyc(6);
    chk(ai1_setting_r, 32'h157C);
    chk(ai2_setting_r, 32'hFFFFEC78);
    @(posedge clock) begin
      ai1_current_mode <= 1'b0;
      ai2_current_mode <= 1'b0;
      analog_input_one <= 16'hFC18;
      curve_select_setting <= 12'h313;
    end
    cyc(6);
    chk(ai1_setting_r, 32'hFFFFD8F0);
    chk(ai2_setting_r, 32'h0);
    @(posedge clock) begin
      curve_select_setting <= 12'h321;
      ai1_filter_time <= 10'h008;
      analog_input_one <= 16'h03E8;
      ai2_filter_time <= 10'h008;
      analog_input_two <= 16'h03E8;
    end
    cyc(10);
    chk(ai1_setting_r !== 16'h2710, 1'b1);
    chk(ai2_setting_r !== 16'h2710, 1'b1);
    cyc(4000);
    chk(ai1_setting_r, 32'h2710);
    chk(ai2_setting_r, 32'h2710);
    done(5);
    @(posedge clock) begin
      pen <= 1'b1;
      p_x_max <= 16'h0014;
    end
    cyc(800);
    chk(pulse_freq_r, 32'hA);
    chk(pulse_setting_r, 32'h1388);
    @(posedge clock) p_x_max <= 16'h4E20;
    cyc(6);
    chk(pulse_setting_r, 32'hA);
    done(6);
    end_sim;
  end
endmodule
